// ### core/sas_sequencer.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
   import sas_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic COMP_IN,
   input wire logic EXT_TRIG,
   input wire logic TIMER_TRIG,
   input wire logic RC_OSC,
   output logic [3:0] MUX_SEL,
   output logic SAMPLE_HOLD,
   output logic [11:0] DAC_CODE,
   output logic REF_EXT,
   output logic CONV_DONE,
   output logic CONV_IRQ_FLAG,
   output logic [15:0] ANALOG_PIN_CFG
);
   typedef struct packed {
      logic on;
      logic [2:0] trig_src;
      logic auto_sample_enable;
      logic sample_start_bit;
      logic done;
      logic ref_ext;
      logic scan_en;
      logic [3:0] samples_per_irq;
      logic split;
      logic alt;
      logic [4:0] auto_sample_clocks;
      logic rc_sel;
      logic [5:0] div;
      logic [3:0] sel_a;
      logic [3:0] sel_b;
      logic [15:0] pcfg;
      logic [15:0] scan_mask;
      logic irq_flag;
      sas_state_t state;
      logic restart;
      logic [3:0] tad_cnt;
      logic [4:0] sample_start_bit_cnt;
      logic [11:0] sar;
      logic [11:0] probe;
      logic [3:0] seq_cnt;
      logic [3:0] wr_ptr;
      logic half;
      logic use_b;
      logic [3:0] scan_idx;
      logic [3:0] mux_sel;
      logic hold;
      logic [1:0] comp_sync;
      logic [2:0] ext_sync;
      logic [BUF_WORDS-1:0][RES_BITS-1:0] mem;
      logic awready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } sas_seq_state_t;

   sas_seq_state_t r;
   sas_seq_state_t n;
   logic [1:0] rst_sync;
   logic rst_n;
   logic tad_tick;
   logic wr_hs;
   logic rd_hs;
   logic trig;
   logic store;
   logic irq_evt;
   logic [15:0] wv;
   logic [15:0] ctrl1_rd;
   logic [15:0] ctrl2_rd;
   logic [15:0] ctrl3_rd;
   logic [15:0] insel_rd;

   // ==========================================
   // helpers
   // byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      logic [15:0] v;
      v = old;
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      return v;
   endfunction

   // lowest marked input at or above start, else lowest marked overall
   function automatic logic [3:0] next_scan(input logic [15:0] m, input logic [4:0] from);
      logic [3:0] low;
      logic [3:0] hit;
      logic found;
      low = 4'h0;
      hit = 4'h0;
      found = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) begin
            low = 4'(i);
            if (i >= int'(from)) begin
               hit = 4'(i);
               found = 1'b1;
            end
         end
      end
      return found ? hit : low;
   endfunction

   // ==========================================
   // reset release
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ==========================================
   // converter clock
   // restart realigns the divided clock so each phase gets whole periods
   sas_tad_gen u_tad (
      .clk(CLK_SYS),
      .rst_n(rst_n),
      .cfg('{rc_sel: r.rc_sel, divisor: r.div}),
      .run(r.state != ST_IDLE && !r.restart),
      .rc_osc_in(RC_OSC),
      .tick(tad_tick)
   );

   // register read views
   always_comb begin
      ctrl1_rd = 16'h0000;
      ctrl1_rd[B_ON] = r.on;
      ctrl1_rd[B_SRC_LO+:3] = r.trig_src;
      ctrl1_rd[B_AUTO_SAMPLE_ENABLE] = r.auto_sample_enable;
      ctrl1_rd[B_SAMPLE_START_BIT] = r.sample_start_bit;
      ctrl1_rd[B_DONE] = r.done;
      ctrl2_rd = 16'h0000;
      ctrl2_rd[B_REF] = r.ref_ext;
      ctrl2_rd[B_SCAN] = r.scan_en;
      ctrl2_rd[B_HALF] = r.half;
      ctrl2_rd[B_SAMPLES_PER_IRQ_LO+:4] = r.samples_per_irq;
      ctrl2_rd[B_SPLIT] = r.split;
      ctrl2_rd[B_ALT] = r.alt;
      ctrl3_rd = 16'h0000;
      ctrl3_rd[B_AUTO_SAMPLE_CLOCKS_LO+:5] = r.auto_sample_clocks;
      ctrl3_rd[B_RC] = r.rc_sel;
      ctrl3_rd[B_DIV_LO+:6] = r.div;
      insel_rd = 16'h0000;
      insel_rd[B_GRPA_LO+:4] = r.sel_a;
      insel_rd[B_GRPB_LO+:4] = r.sel_b;
   end

   // ==========================================
   // next state
   always_comb begin
      n = r;
      n.comp_sync = {r.comp_sync[0], COMP_IN};
      n.ext_sync = {r.ext_sync[1:0], EXT_TRIG};
      n.restart = 1'b0;
      wr_hs = AWVALID && r.awready;
      rd_hs = ARVALID && r.arready;
      wv = merge16(16'h0000, WDATA, WSTRB);
      trig = 1'b0;
      store = 1'b0;
      irq_evt = 1'b0;

      // write channel: address and data taken together
      n.awready = AWVALID && WVALID && !r.awready && !r.bvalid;
      if (wr_hs) begin
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         unique case (AWADDR)
            OFF_CTRL1: begin
               wv = merge16(ctrl1_rd, WDATA, WSTRB);
               n.on = wv[B_ON];
               n.trig_src = wv[B_SRC_LO+:3];
               n.auto_sample_enable = wv[B_AUTO_SAMPLE_ENABLE];
               n.sample_start_bit = wv[B_SAMPLE_START_BIT];
            end
            OFF_CTRL2: begin
               // taken as written; stable while on is up to software
               wv = merge16(ctrl2_rd, WDATA, WSTRB);
               n.ref_ext = wv[B_REF];
               n.scan_en = wv[B_SCAN];
               n.samples_per_irq = wv[B_SAMPLES_PER_IRQ_LO+:4];
               n.split = wv[B_SPLIT];
               n.alt = wv[B_ALT];
            end
            OFF_CTRL3: begin
               wv = merge16(ctrl3_rd, WDATA, WSTRB);
               n.auto_sample_clocks = wv[B_AUTO_SAMPLE_CLOCKS_LO+:5];
               n.rc_sel = wv[B_RC];
               n.div = wv[B_DIV_LO+:6];
            end
            OFF_INSEL: begin
               wv = merge16(insel_rd, WDATA, WSTRB);
               n.sel_a = wv[B_GRPA_LO+:4];
               n.sel_b = wv[B_GRPB_LO+:4];
            end
            OFF_PCFG: n.pcfg = merge16(r.pcfg, WDATA, WSTRB);
            OFF_SCAN: n.scan_mask = merge16(r.scan_mask, WDATA, WSTRB);
            // flag can only be cleared from software
            OFF_STAT: n.irq_flag = r.irq_flag & (wv[B_IRQ] | !WSTRB[0]);
            default: begin
               // buffer writes are accepted but change nothing
               if (AWADDR[7:6] != BUF_PAGE) n.bresp = RESP_SLVERR;
            end
         endcase
      end else if (BREADY && r.bvalid) begin
         n.bvalid = 1'b0;
      end

      // read channel
      n.arready = ARVALID && !r.arready && !r.rvalid;
      if (rd_hs) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = 32'h0000_0000;
         unique case (ARADDR)
            OFF_CTRL1: n.rdata[15:0] = ctrl1_rd;
            OFF_CTRL2: n.rdata[15:0] = ctrl2_rd;
            OFF_CTRL3: n.rdata[15:0] = ctrl3_rd;
            OFF_INSEL: n.rdata[15:0] = insel_rd;
            OFF_PCFG: n.rdata[15:0] = r.pcfg;
            OFF_SCAN: n.rdata[15:0] = r.scan_mask;
            OFF_STAT: n.rdata[B_IRQ] = r.irq_flag;
            default: begin
               if (ARADDR[7:6] == BUF_PAGE) n.rdata[RES_BITS-1:0] = r.mem[ARADDR[5:2]];
               else n.rresp = RESP_SLVERR;
            end
         endcase
      end else if (RREADY && r.rvalid) begin
         n.rvalid = 1'b0;
      end

      // sequencer; the on bit after this cycle's write is used,
      // so a disable always beats a trigger in the same cycle
      unique case (r.state)
         ST_IDLE: begin
            if (n.sample_start_bit) begin
               n.state = ST_SAMPLE;
               n.hold = 1'b1;
               n.sample_start_bit_cnt = 5'h00;
            end
         end
         ST_SAMPLE: begin
            if (tad_tick) n.sample_start_bit_cnt = r.sample_start_bit_cnt + 5'h01;
            // four sources; other codes never trigger
            case (r.trig_src)
               TRIG_SW: trig = !n.sample_start_bit;
               // a zero count fires on the first clock
               TRIG_AUTO: trig = tad_tick && (r.sample_start_bit_cnt + 5'h01 >= r.auto_sample_clocks);
               TRIG_TIMER: trig = TIMER_TRIG;
               TRIG_EXT: trig = r.ext_sync[1] && !r.ext_sync[2];
               default: trig = 1'b0;
            endcase
            if (trig) begin
               n.state = ST_CONVERT;
               n.hold = 1'b0;
               n.tad_cnt = 4'h0;
               n.sar = SAR_MSB;
               n.probe = SAR_MSB;
               n.done = 1'b0;
               if (r.trig_src != TRIG_SW) n.sample_start_bit = 1'b0;
            end
         end
         ST_CONVERT: begin
            if (tad_tick) begin
               n.tad_cnt = r.tad_cnt + 4'h1;
               // clocks 2..13 resolve one bit each, msb first
               if (r.tad_cnt >= 4'h1 && r.tad_cnt <= 4'(RES_BITS)) begin
                  n.sar = (r.comp_sync[1] ? r.sar : (r.sar & ~r.probe)) | (r.probe >> 1);
                  n.probe = r.probe >> 1;
               end
               store = (r.tad_cnt == 4'(CONV_TADS - 1)) && n.on;
            end
         end
         default: n.state = ST_IDLE;
      endcase

      // result storage and interrupt event
      if (store) begin
         n.mem[r.wr_ptr] = r.sar;
         n.seq_cnt = r.seq_cnt + 4'h1;
         n.wr_ptr = r.split ? {r.half, r.wr_ptr[2:0] + 3'h1} : r.wr_ptr + 4'h1;
         if (!r.use_b && r.scan_en) n.scan_idx = next_scan(r.scan_mask, {1'b0, r.scan_idx} + 5'h01);
         n.use_b = r.alt && !r.use_b;
         // field holds count minus one
         if (r.seq_cnt == r.samples_per_irq) begin
            irq_evt = 1'b1;
            n.done = 1'b1;
            n.irq_flag = 1'b1;
            n.seq_cnt = 4'h0;
            n.half = r.split && !r.half;
            n.wr_ptr = r.split ? {!r.half, 3'h0} : 4'h0;
            n.scan_idx = next_scan(r.scan_mask, 5'h00);
         end
         n.state = r.auto_sample_enable ? ST_SAMPLE : ST_IDLE;
         n.hold = r.auto_sample_enable;
         n.sample_start_bit_cnt = 5'h00;
         if (r.auto_sample_enable) n.sample_start_bit = 1'b1;
      end

      // off: abort everything, buffer untouched
      if (!n.on) begin
         n.state = ST_IDLE;
         n.hold = 1'b0;
         n.sample_start_bit = 1'b0;
         n.seq_cnt = 4'h0;
         n.half = 1'b0;
         n.wr_ptr = 4'h0;
         n.use_b = 1'b0;
         n.scan_idx = next_scan(r.scan_mask, 5'h00);
      end

      // input chosen as each acquisition opens
      if (n.state == ST_SAMPLE && r.state != ST_SAMPLE) begin
         n.mux_sel = n.use_b ? r.sel_b : (r.scan_en ? n.scan_idx : r.sel_a);
      end
      n.restart = n.state != r.state;
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ==========================================
   // outputs
   assign AWREADY = r.awready;
   assign WREADY = r.awready;
   assign BVALID = r.bvalid;
   assign BRESP = r.bresp;
   assign ARREADY = r.arready;
   assign RVALID = r.rvalid;
   assign RRESP = r.rresp;
   assign RDATA = r.rdata;
   assign MUX_SEL = r.mux_sel;
   assign SAMPLE_HOLD = r.hold;
   assign DAC_CODE = r.sar;
   assign REF_EXT = r.ref_ext;
   assign CONV_DONE = r.done;
   assign CONV_IRQ_FLAG = r.irq_flag;
   assign ANALOG_PIN_CFG = r.pcfg;

   // ==========================================
   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   a_sample_begin: assert property ((r.state == ST_IDLE && r.on && r.sample_start_bit && !wr_hs)
      |=> (r.state == ST_SAMPLE && r.hold)) else $error("acquisition did not start");
   a_sw_trigger: assert property ((r.state == ST_SAMPLE && r.on && r.trig_src == TRIG_SW
      && !r.sample_start_bit && !wr_hs) |=> r.state == ST_CONVERT) else $error("software trigger missed");
   a_auto_trigger: assert property ((r.state == ST_SAMPLE && r.on && r.trig_src == TRIG_AUTO
      && tad_tick && r.sample_start_bit_cnt + 5'h01 >= r.auto_sample_clocks && !wr_hs) |=> r.state == ST_CONVERT)
      else $error("auto trigger missed");
   a_conv_ends: assert property ((r.state == ST_CONVERT && tad_tick && r.tad_cnt == 4'hd)
      |=> r.state != ST_CONVERT) else $error("conversion overran 14 clocks");
   a_conv_holds: assert property ((r.state == ST_CONVERT && r.tad_cnt < 4'hd)
      |=> (r.state == ST_CONVERT || !r.on)) else $error("conversion ended early");
   a_off_idle: assert property (!r.on |-> (r.state == ST_IDLE && !r.hold))
      else $error("sequencing while off");
   a_off_wins: assert property ((r.state == ST_SAMPLE && wr_hs && AWADDR == OFF_CTRL1
      && WSTRB[1] && !WDATA[B_ON]) |=> r.state == ST_IDLE) else $error("start beat disable");
   a_buf_readonly: assert property ($changed(r.mem) |-> $past(store))
      else $error("buffer changed without a result");
   a_irq_count: assert property ($rose(r.irq_flag) |-> $past(r.seq_cnt) == $past(r.samples_per_irq))
      else $error("irq flag at wrong count");
   a_split_half: assert property ((irq_evt && r.split) |=> r.half != $past(r.half))
      else $error("buffer half not swapped");
   a_ptr_restart: assert property (irq_evt |=>
      (r.split ? r.wr_ptr == {r.half, 3'h0} : r.wr_ptr == 4'h0)) else $error("pointer not reset");
   a_group_a_only: assert property (($rose(r.state == ST_SAMPLE) && !r.alt && !r.scan_en)
      |-> r.mux_sel == r.sel_a) else $error("wrong input group");

   c_irq_event: cover property (irq_evt);
   c_split_swap: cover property (irq_evt && r.split);
   c_abort: cover property (r.state == ST_CONVERT ##1 r.state == ST_IDLE);
   c_scan_store: cover property (store && r.scan_en);
endmodule
`default_nettype wire

// ### include/sas_pkg.sv
package sas_pkg;
   // ==========================================
   // geometry and timing
   localparam int RES_BITS = 12;
   localparam int BUF_WORDS = 16;
   localparam int CONV_TADS = 14;
   // instruction cycle in system clocks
   localparam int SYS_PER_INSTR = 2;
   localparam logic [11:0] SAR_MSB = 12'h800;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_CTRL3 = 8'h08;
   localparam logic [7:0] OFF_INSEL = 8'h0c;
   localparam logic [7:0] OFF_PCFG = 8'h10;
   localparam logic [7:0] OFF_SCAN = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;
   localparam logic [1:0] BUF_PAGE = 2'h1;
   // ==========================================
   // field positions
   localparam int B_ON = 15;
   localparam int B_SRC_LO = 5;
   localparam int B_AUTO_SAMPLE_ENABLE = 2;
   localparam int B_SAMPLE_START_BIT = 1;
   localparam int B_DONE = 0;
   localparam int B_REF = 13;
   localparam int B_SCAN = 10;
   localparam int B_HALF = 7;
   localparam int B_SAMPLES_PER_IRQ_LO = 2;
   localparam int B_SPLIT = 1;
   localparam int B_ALT = 0;
   localparam int B_AUTO_SAMPLE_CLOCKS_LO = 8;
   localparam int B_RC = 7;
   localparam int B_DIV_LO = 0;
   localparam int B_GRPA_LO = 0;
   localparam int B_GRPB_LO = 8;
   localparam int B_IRQ = 0;
   // ==========================================
   // bus answers and encodings
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b11
   } sas_state_t;
   typedef enum logic [2:0] {
      TRIG_SW = 3'h0,
      TRIG_EXT = 3'h1,
      TRIG_TIMER = 3'h2,
      TRIG_AUTO = 3'h7
   } sas_trig_t;
   typedef struct packed {
      logic rc_sel;
      logic [5:0] divisor;
   } sas_tad_cfg_t;
endpackage

// ### core/sas_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sas_tad_gen
   import sas_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire sas_tad_cfg_t cfg,
   input wire logic run,
   input wire logic rc_osc_in,
   output logic tick
);
   typedef struct packed {
      logic [2:0] rc_sync;
      logic [6:0] cnt;
      logic tick;
   } sas_tad_state_t;
   sas_tad_state_t r;
   sas_tad_state_t n;
   logic [6:0] limit;

   // ==========================================
   // converter clock: divided or rc edges
   // period in sys clocks = (divisor+1) * half instruction cycle
   assign limit = 7'((int'(cfg.divisor) + 1) * SYS_PER_INSTR / 2);
   always_comb begin
      n = r;
      n.rc_sync = {r.rc_sync[1:0], rc_osc_in};
      n.tick = 1'b0;
      if (!run) begin
         n.cnt = 7'h00;
      end else if (cfg.rc_sel) begin
         // rc pin must be slower than two sys clocks per phase
         n.tick = r.rc_sync[1] && !r.rc_sync[2];
      end else if (r.cnt >= limit - 7'h01) begin
         n.tick = 1'b1;
         n.cnt = 7'h00;
      end else begin
         n.cnt = r.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign tick = r.tick;
endmodule
`default_nettype wire

// ### sim/sas_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
   input wire logic clk,
   input wire logic [3:0] mux_sel,
   input wire logic sample_hold,
   input wire logic [11:0] dac_code,
   output logic comp_in
);
   // ==========================================
   // analog inputs, set by the bench
   logic [11:0] lvl [16];
   logic [11:0] held = 12'h000;
   // hold cap follows the routed input only while the switch is closed
   always_ff @(posedge clk) begin
      if (sample_hold) begin
         held <= lvl[mux_sel];
      end
   end
   // ideal comparator, no offset: a real one would blur the lsb
   assign comp_in = (held >= dac_code);
endmodule
`default_nettype wire

// ### sim/test_sar_adc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_sequencer
   import sas_pkg::*;
;
   // ==========================================
   // stimulus and observed signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic ext_trig = 1'b0, timer_trig = 1'b0, rc_osc = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, comp_in, sample_hold, ref_ext, conv_done, irq;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, d;
   logic [3:0] mux_sel, ch;
   logic [11:0] dac_code;
   logic [15:0] pin_cfg, mask;
   logic [2:0] src;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   // free-running rc source, unused unless rc select is set
   always #61 rc_osc = ~rc_osc;
   sas_sequencer u_dut (.CLK_SYS(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(4'h3), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .COMP_IN(comp_in), .EXT_TRIG(ext_trig), .TIMER_TRIG(timer_trig),
      .RC_OSC(rc_osc), .MUX_SEL(mux_sel), .SAMPLE_HOLD(sample_hold), .DAC_CODE(dac_code), .REF_EXT(ref_ext),
      .CONV_DONE(conv_done), .CONV_IRQ_FLAG(irq), .ANALOG_PIN_CFG(pin_cfg));
   sas_analog_model u_ana (.clk(clk), .mux_sel(mux_sel), .sample_hold(sample_hold), .dac_code(dac_code),
      .comp_in(comp_in));
   // ==========================================
   // bus tasks: ready is looked at mid-cycle, so it is the value sampled at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge clk); while (awready !== 1'b1);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      do @(negedge clk); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_irq();
      do @(negedge clk); while (irq !== 1'b1);
   endtask
   // k-th input visited by the scan, lowest marked first, wrapping
   function automatic logic [3:0] scan_ch(input logic [15:0] m, input int k);
      logic [3:0] list [16];
      int n;
      n = 0;
      for (int i = 0; i < 16; i++) begin
         if (m[i]) begin
            list[n] = 4'(i);
            n++;
         end
      end
      return list[k % n];
   endfunction
   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         end_of_test();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      logic [2:0] codes [4];
      codes = '{3'h0, 3'h1, 3'h2, 3'h7};
      void'($urandom(29));
      for (int i = 0; i < 16; i++) begin
         u_ana.lvl[i] = 12'($urandom);
      end
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rd(OFF_CTRL1);
      chk("ctrl1 reset", 32'h0, d);
      rd(8'h20);
      chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
      // tad of 6 system clocks leaves room for the comparator sync
      wr(OFF_CTRL3, 32'h0205);
      for (int t = 0; t < 4; t++) begin
         src = codes[t];
         ch = 4'($urandom);
         wr(OFF_INSEL, {28'h0, ch});
         wr(OFF_CTRL1, 32'h8000 | (32'(src) << B_SRC_LO));
         wr(OFF_CTRL1, 32'h8002 | (32'(src) << B_SRC_LO));
         @(negedge clk);
         chk("sample hold", 32'h1, {31'h0, sample_hold});
         chk("mux sel", {28'h0, ch}, {28'h0, mux_sel});
         if (src == 3'h0) begin
            wr(OFF_CTRL1, 32'h8000);
         end else if (src == 3'h1) begin
            @(posedge clk);
            ext_trig <= 1'b1;
            repeat (4) @(posedge clk);
            ext_trig <= 1'b0;
         end else if (src == 3'h2) begin
            @(posedge clk);
            timer_trig <= 1'b1;
            @(posedge clk);
            timer_trig <= 1'b0;
         end
         wait_irq();
         chk("done pin", 32'h1, {31'h0, conv_done});
         rd(8'h40);
         chk("result", {20'h0, u_ana.lvl[ch]}, d);
         wr(OFF_STAT, 32'h0);
         wr(OFF_CTRL1, 32'h0);
      end
      // buffer is read only from the bus
      wr(8'h40, 32'h0fff);
      chk("buffer write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
      rd(8'h40);
      chk("buffer kept", {20'h0, u_ana.lvl[ch]}, d);
      wr(8'h24, 32'h1);
      chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, resp});
      // split buffer, eight per irq, scanning group a in auto mode
      mask = 16'($urandom) | 16'h0001;
      wr(OFF_SCAN, {16'h0, mask});
      wr(OFF_CTRL2, 32'h041e);
      wr(OFF_CTRL1, 32'h80e6);
      wait_irq();
      wr(OFF_STAT, 32'h0);
      wait_irq();
      // third batch is cut off during its first acquisition, before any conversion starts
      wr(OFF_CTRL1, 32'h0);
      wr(OFF_STAT, 32'h0);
      repeat (300) @(posedge clk);
      @(negedge clk);
      chk("irq after off", 32'h0, {31'h0, irq});
      chk("hold after off", 32'h0, {31'h0, sample_hold});
      for (int k = 0; k < 8; k++) begin
         rd(8'(8'h40 + 4 * k));
         chk("half zero", {20'h0, u_ana.lvl[scan_ch(mask, k)]}, d);
         rd(8'(8'h60 + 4 * k));
         chk("half one", {20'h0, u_ana.lvl[scan_ch(mask, k)]}, d);
      end
      // pin config and reference pins, then one auto conversion clocked from the rc pin
      mask = 16'($urandom);
      wr(OFF_PCFG, {16'h0, mask});
      chk("pin cfg", {16'h0, mask}, {16'h0, pin_cfg});
      wr(OFF_CTRL2, 32'h2000);
      chk("ref ext", 32'h1, {31'h0, ref_ext});
      wr(OFF_CTRL3, 32'h0285);
      ch = 4'($urandom);
      wr(OFF_INSEL, {28'h0, ch});
      wr(OFF_CTRL1, 32'h80e2);
      wait_irq();
      rd(8'h40);
      chk("rc result", {20'h0, u_ana.lvl[ch]}, d);
      end_of_test();
   end
endmodule
`default_nettype wire
